// [hw/ufplhc_ctrl.sv]
// Upstream receive lane map, aux channel, link training and hot-plug control
`timescale 1ns/100ps
module ufplhc_ctrl #(
  parameter int LANE_W        = ufplhc_pkg::LANE_W_DEF,
  parameter int IRQ_PULSE_CYC = ufplhc_pkg::IRQ_PULSE_CYC
) (
  input  wire logic                                  clk,
  input  wire logic                                  rst_n,
  input  wire logic                                  ce,
  input  wire ufplhc_pkg::ufplhc_cfg_t               cfg_in,
  input  wire logic [ufplhc_pkg::LANES-1:0][LANE_W-1:0] phy_lane,
  input  wire logic                                  aux_pos_sideband_pin,
  input  wire logic                                  aux_neg_sideband_pin,
  output logic [ufplhc_pkg::LANES-1:0][LANE_W-1:0]      main_lane,
  output logic [LANE_W-1:0]                          usb_rx_lane,
  output logic [LANE_W-1:0]                          usb_tx_lane,
  output logic                                       aux_p_out,
  output logic                                       aux_n_out,
  input  wire ufplhc_pkg::ufplhc_aux_req_t           aux_req,
  output ufplhc_pkg::ufplhc_aux_rsp_t                aux_rsp,
  output logic                                       aux_busy,
  output logic [ufplhc_pkg::EDID_ADDR_W-1:0]         edid_addr,
  output logic                                       edid_rd,
  input  wire logic [7:0]                            edid_data,
  input  wire logic [ufplhc_pkg::LANES-1:0]          lane_cr_done,
  input  wire logic                                  altmode_policy,
  input  wire logic                                  power_off,
  input  wire logic                                  downstream_hotplug_in,
  output logic                                       upstream_hotplug_out,
  output logic                                       link_up,
  output logic [ufplhc_pkg::LANE_CNT_W-1:0]          trained_lanes
);
  import ufplhc_pkg::*;

  localparam int CNT_W = $clog2(IRQ_PULSE_CYC + 1);

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  logic [2:0] pins_s;
  logic       aux_pos_s, aux_neg_s, hpd_s;

  ufplhc_sync3 #(.W(3)) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .async_in ({downstream_hotplug_in, aux_neg_sideband_pin, aux_pos_sideband_pin}),
    .sync_out (pins_s)
  );
  assign aux_pos_s = pins_s[0];
  assign aux_neg_s = pins_s[1];
  assign hpd_s     = pins_s[2];

  // ---------------------------------------------------------------------------
  // Lane and aux mapping
  // ---------------------------------------------------------------------------
  ufplhc_cfg_t                         cfg_q, cfg_d;
  ufplhc_lt_t                          lt_q, lt_d;
  logic [LANES-1:0][LANE_W-1:0]        ml_q, ml_d;
  logic [LANE_W-1:0]                   usb_rx_q, usb_rx_d, usb_tx_q, usb_tx_d;
  logic                                aux_p_q, aux_p_d, aux_n_q, aux_n_d;

  // Source lane for main lane m: {valid, physical index}
  function automatic logic [2:0] lane_src(input ufplhc_cfg_t c, input logic [1:0] m);
    logic [2:0] r;
    r = {1'b1, m};
    if (!c.typec)
      r = {1'b1, m};
    else if (!c.flipped_dp_assignment)
      r = (c.usb_assignment && m[1]) ? 3'h0 : {1'b1, m ^ 2'h2};
    else
      r = (c.usb_assignment && m[1]) ? 3'h0 : {1'b1, m ^ 2'h1};
    return r;
  endfunction

  for (genvar m = 0; m < LANES; m++)
  begin : g_lane
    logic [2:0] src;
    assign src     = lane_src(cfg_q, 2'(m));
    assign ml_d[m] = src[2] ? phy_lane[src[1:0]] : '0;
  end

  always_comb
  begin
    // map only changes while training is idle (LT_IDLE), not in LT_CR, LT_EQ or LT_UP
    cfg_d    = (lt_q == LT_IDLE) ? cfg_in : cfg_q;
    usb_rx_d = '0;
    usb_tx_d = '0;
    if (cfg_q.typec && cfg_q.usb_assignment)
    begin
      if (!cfg_q.flipped_dp_assignment)
      begin
        // USB on lanes 0 and 1
        usb_rx_d = phy_lane[0];
        usb_tx_d = phy_lane[1];
      end
      else
      begin
        // USB on lanes 2 and 3
        usb_tx_d = phy_lane[2];
        usb_rx_d = phy_lane[3];
      end
    end
    if (cfg_q.typec && cfg_q.flipped_dp_assignment)
    begin
      aux_p_d = aux_neg_s;
      aux_n_d = aux_pos_s;
    end
    else
    begin
      aux_p_d = aux_pos_s;
      aux_n_d = aux_neg_s;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cfg_q    <= '0;
      ml_q     <= '0;
      usb_rx_q <= '0;
      usb_tx_q <= '0;
      aux_p_q  <= 1'b0;
      aux_n_q  <= 1'b0;
    end
    else if (ce)
    begin
      cfg_q    <= cfg_d;
      ml_q     <= ml_d;
      usb_rx_q <= usb_rx_d;
      usb_tx_q <= usb_tx_d;
      aux_p_q  <= aux_p_d;
      aux_n_q  <= aux_n_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Aux transactions and link training
  // ---------------------------------------------------------------------------
  ufplhc_aux_rsp_t          rsp_q, rsp_d;
  logic                     pend_q, pend_d, pend_mot_q, pend_mot_d;
  logic [7:0]               seg_q, seg_d, ofs_q, ofs_d;
  logic [EDID_ADDR_W-1:0]   eaddr_q, eaddr_d;
  logic                     erd_q, erd_d;
  logic [7:0]               bw_q, bw_d, pwr_q, pwr_d;
  logic [LANE_CNT_W-1:0]    lcnt_q, lcnt_d;
  logic [TP_W-1:0]          tp_q, tp_d;
  logic                     up_q, up_d;
  logic                     hpd_q;

  // All lanes in use have finished clock recovery
  function automatic logic lanes_ok(input logic [LANE_CNT_W-1:0] n, input logic [LANES-1:0] cr);
    logic r;
    r = cr[0];
    if (n == 5'h04)
      r = &cr;
    else if (n == 5'h02)
      r = &cr[1:0];
    return r;
  endfunction

  function automatic logic [LANE_CNT_W-1:0] trim(input logic [LANE_CNT_W-1:0] n, input logic [LANES-1:0] cr);
    logic [LANE_CNT_W-1:0] r;
    r = 5'h01;
    if (&cr)
      r = 5'h04;
    else if (&cr[1:0])
      r = 5'h02;
    return (r < n) ? r : n;
  endfunction

  always_comb
  begin
    logic take, nat, rd, mot;
    logic [6:0] ia;
    take    = aux_req.valid && !pend_q;
    nat     = aux_req.cmd[AUX_NATIVE_BIT];
    rd      = aux_req.cmd[0];
    mot     = aux_req.cmd[AUX_MOT_BIT];
    ia      = aux_req.addr[6:0];
    rsp_d   = '0;
    pend_d  = 1'b0;
    pend_mot_d = pend_mot_q;
    seg_d   = seg_q;
    ofs_d   = ofs_q;
    eaddr_d = eaddr_q;
    erd_d   = 1'b0;
    bw_d    = bw_q;
    pwr_d   = pwr_q;
    lcnt_d  = lcnt_q;
    tp_d    = tp_q;
    lt_d    = lt_q;
    if (pend_q)
    begin
      rsp_d = '{valid: 1'b1, reply: AUX_ACK, rdata: edid_data};
      ofs_d = ofs_q + 8'h01;
      // segment pointer lapses at the end of the read
      if (!pend_mot_q)
        seg_d = '0;
    end
    else if (take && nat)
    begin
      // native access to the capability map
      rsp_d = '{valid: 1'b1, reply: AUX_ACK, rdata: 8'h00};
      if (rd)
      begin
        unique case (aux_req.addr)
          DPCD_LINK_BW:   rsp_d.rdata = bw_q;
          DPCD_LANE_CNT:  rsp_d.rdata = {3'h0, lcnt_q};
          DPCD_TRAIN_PAT: rsp_d.rdata = {4'h0, tp_q};
          DPCD_SINK_CNT:  rsp_d.rdata = hpd_q ? SINK_ONE : SINK_NONE;
          DPCD_LANE01_ST:
          begin
            rsp_d.rdata[LS_CR_LO] = lane_cr_done[0];
            rsp_d.rdata[LS_CR_HI] = lane_cr_done[1];
          end
          DPCD_LANE23_ST:
          begin
            rsp_d.rdata[LS_CR_LO] = lane_cr_done[2];
            rsp_d.rdata[LS_CR_HI] = lane_cr_done[3];
          end
          DPCD_PWR_STATE: rsp_d.rdata = pwr_q;
          default:        rsp_d.rdata = 8'h00;
        endcase
      end
      else
      begin
        unique case (aux_req.addr)
          DPCD_LINK_BW:  bw_d = aux_req.wdata;
          DPCD_LANE_CNT: lcnt_d = aux_req.wdata[LANE_CNT_W-1:0];
          DPCD_TRAIN_PAT:
          begin
            tp_d = aux_req.wdata[TP_W-1:0];
            if (tp_d == TP_1)
              lt_d = LT_CR;
            else if (tp_d == TP_2 || tp_d == TP_3 || tp_d == TP_4)
            begin
              lt_d = LT_EQ;
              if (altmode_policy && lt_q == LT_CR)
                lcnt_d = trim(lcnt_q, lane_cr_done);
            end
            else if (tp_d == TP_NONE)
              lt_d = (lt_q == LT_EQ && lanes_ok(lcnt_q, lane_cr_done)) ? LT_UP : LT_IDLE;
          end
          DPCD_PWR_STATE:
          begin
            pwr_d = aux_req.wdata;
            // power-down drops the link until retrained
            if (aux_req.wdata == PWR_DOWN)
              lt_d = LT_IDLE;
          end
          default: ;
        endcase
      end
    end
    else if (take)
    begin
      rsp_d = '{valid: 1'b1, reply: AUX_ACK, rdata: 8'h00};
      if (ia == I2C_SEG_ADDR)
      begin
        // segment write precedes the offset read
        if (!rd)
          seg_d = aux_req.wdata;
      end
      else if (ia == I2C_EDID_ADDR)
      begin
        if (!rd)
          ofs_d = aux_req.wdata;
        else
        begin
          // Answer waits one cycle for the EDID store
          rsp_d      = '0;
          pend_d     = 1'b1;
          pend_mot_d = mot;
          eaddr_d    = {seg_q, ofs_q};
          erd_d      = 1'b1;
        end
      end
      else
        rsp_d.reply = AUX_NACK;
    end
    up_d = (lt_d == LT_UP);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rsp_q      <= '0;
      pend_q     <= 1'b0;
      pend_mot_q <= 1'b0;
      seg_q      <= '0;
      ofs_q      <= '0;
      eaddr_q    <= '0;
      erd_q      <= 1'b0;
      bw_q       <= LINK_BW_RST;
      pwr_q      <= PWR_STATE_RST;
      lcnt_q     <= LANE_CNT_RST;
      tp_q       <= TP_NONE;
      lt_q       <= LT_IDLE;
      up_q       <= 1'b0;
    end
    else if (ce)
    begin
      rsp_q      <= rsp_d;
      pend_q     <= pend_d;
      pend_mot_q <= pend_mot_d;
      seg_q      <= seg_d;
      ofs_q      <= ofs_d;
      eaddr_q    <= eaddr_d;
      erd_q      <= erd_d;
      bw_q       <= bw_d;
      pwr_q      <= pwr_d;
      lcnt_q     <= lcnt_d;
      tp_q       <= tp_d;
      lt_q       <= lt_d;
      up_q       <= up_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Hot-plug
  // ---------------------------------------------------------------------------
  logic             hpd_d, hp_out_q, hp_out_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;

  always_comb
  begin
    hpd_d = hpd_s;
    cnt_d = cnt_q;
    // every downstream change restarts the pulse
    if (hpd_s != hpd_q)
      cnt_d = CNT_W'(IRQ_PULSE_CYC);
    else if (cnt_q != '0)
      cnt_d = cnt_q - 1'b1;
    // high when powered and no pulse is counting, low for the pulse after a downstream change
    hp_out_d = !power_off && (cnt_d == '0);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      hpd_q    <= 1'b0;
      cnt_q    <= '0;
      hp_out_q <= 1'b1;
    end
    else if (ce)
    begin
      hpd_q    <= hpd_d;
      cnt_q    <= cnt_d;
      hp_out_q <= hp_out_d;
    end
  end

  assign main_lane            = ml_q;
  assign usb_rx_lane          = usb_rx_q;
  assign usb_tx_lane          = usb_tx_q;
  assign aux_p_out            = aux_p_q;
  assign aux_n_out            = aux_n_q;
  assign aux_rsp              = rsp_q;
  assign aux_busy             = pend_q;
  assign edid_addr            = eaddr_q;
  assign edid_rd              = erd_q;
  assign upstream_hotplug_out = hp_out_q;
  assign link_up              = up_q;
  assign trained_lanes        = lcnt_q;
endmodule // ufplhc_ctrl

// [hw/ufplhc_pkg.sv]
// Constants, types and carriers for the upstream lane map and hot-plug controller
//-----------------------------------------------------------------------------
//-----------------------------------------------------------------------------
package ufplhc_pkg;

  localparam int LANES        = 4;
  localparam int LANE_W_DEF   = 20;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_FREQ_MHZ = 125;
  // Middle of the 0.5 ms .. 1 ms window, away from both edges
  localparam int IRQ_PULSE_NS = 750000;
  localparam int IRQ_PULSE_CYC = (IRQ_PULSE_NS / 1000) * CLK_FREQ_MHZ;

  // ---------------------------------------------------------------------------
  // Aux request and reply codes
  // ---------------------------------------------------------------------------
  localparam logic [3:0] AUX_CMD_I2C_WR    = 4'h0;
  localparam logic [3:0] AUX_CMD_I2C_RD    = 4'h1;
  localparam logic [3:0] AUX_CMD_NATIVE_WR = 4'h8;
  localparam logic [3:0] AUX_CMD_NATIVE_RD = 4'h9;
  localparam int         AUX_NATIVE_BIT    = 3;
  localparam int         AUX_MOT_BIT       = 2;
  localparam logic [1:0] AUX_ACK           = 2'h0;
  localparam logic [1:0] AUX_NACK          = 2'h1;

  // ---------------------------------------------------------------------------
  // Capability map addresses and fields
  // ---------------------------------------------------------------------------
  localparam logic [19:0] DPCD_LINK_BW    = 20'h00100;
  localparam logic [19:0] DPCD_LANE_CNT   = 20'h00101;
  localparam logic [19:0] DPCD_TRAIN_PAT  = 20'h00102;
  localparam logic [19:0] DPCD_SINK_CNT   = 20'h00200;
  localparam logic [19:0] DPCD_LANE01_ST  = 20'h00202;
  localparam logic [19:0] DPCD_LANE23_ST  = 20'h00203;
  localparam logic [19:0] DPCD_PWR_STATE  = 20'h00600;

  localparam logic [7:0] LINK_BW_RST     = 8'h06;
  localparam logic [4:0] LANE_CNT_RST    = 5'h04;
  localparam logic [7:0] PWR_STATE_RST   = 8'h01;
  localparam logic [7:0] PWR_DOWN        = 8'h02;
  localparam int         LANE_CNT_W      = 5;
  localparam int         TP_W            = 4;
  localparam logic [3:0] TP_NONE         = 4'h0;
  localparam logic [3:0] TP_1            = 4'h1;
  localparam logic [3:0] TP_2            = 4'h2;
  localparam logic [3:0] TP_3            = 4'h3;
  localparam logic [3:0] TP_4            = 4'h7;
  localparam int         LS_CR_LO        = 0;
  localparam int         LS_CR_HI        = 4;
  localparam logic [7:0] SINK_ONE        = 8'h01;
  localparam logic [7:0] SINK_NONE       = 8'h00;

  // ---------------------------------------------------------------------------
  // E-DDC addressing over I2C-over-aux
  // ---------------------------------------------------------------------------
  localparam logic [6:0] I2C_EDID_ADDR   = 7'h50;
  localparam logic [6:0] I2C_SEG_ADDR    = 7'h30;
  localparam int         EDID_ADDR_W     = 16;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {LT_IDLE, LT_CR, LT_EQ, LT_UP} ufplhc_lt_t;

  typedef struct packed {
    logic typec;
    logic flipped_dp_assignment;
    logic usb_assignment;
  } ufplhc_cfg_t;

  typedef struct packed {
    logic        valid;
    logic [3:0]  cmd;
    logic [19:0] addr;
    logic [7:0]  wdata;
  } ufplhc_aux_req_t;

  typedef struct packed {
    logic       valid;
    logic [1:0] reply;
    logic [7:0] rdata;
  } ufplhc_aux_rsp_t;

endpackage

// [hw/ufplhc_sync3.sv]
// Three-stage synchroniser for pin inputs with agreement filter
`timescale 1ns/100ps
module ufplhc_sync3 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] s1_q, s2_q, s3_q, out_q;
  logic [W-1:0] out_d;

  // A change counts only once stages two and three agree
  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      out_q <= '0;
    end
    else if (ce)
    begin
      s1_q  <= async_in;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end

  assign sync_out = out_q;
endmodule // ufplhc_sync3

// [verification/ufplhc_ctrl_checker.sv]
// Concurrent checks on the ports of the upstream lane map and hot-plug controller
`timescale 1ns/100ps
module ufplhc_ctrl_checker #(
  parameter int LANE_W        = 20,
  parameter int IRQ_PULSE_CYC = 20
) (
  input wire logic                                     clk,
  input wire logic                                     rst_n,
  input wire logic                                     ce,
  input wire ufplhc_pkg::ufplhc_cfg_t                  cfg_in,
  input wire logic [ufplhc_pkg::LANES-1:0][LANE_W-1:0] phy_lane,
  input wire logic [ufplhc_pkg::LANES-1:0][LANE_W-1:0] main_lane,
  input wire logic [LANE_W-1:0]                        usb_rx_lane,
  input wire logic [LANE_W-1:0]                        usb_tx_lane,
  input wire ufplhc_pkg::ufplhc_aux_req_t              aux_req,
  input wire ufplhc_pkg::ufplhc_aux_rsp_t              aux_rsp,
  input wire logic                                     aux_busy,
  input wire logic                                     edid_rd,
  input wire logic                                     power_off,
  input wire logic                                     upstream_hotplug_out,
  input wire logic                                     link_up,
  input wire logic [ufplhc_pkg::LANE_CNT_W-1:0]        trained_lanes
);
  import ufplhc_pkg::*;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // ------------------------------------------------
  // Low stretch length on the hot-plug line
  // ------------------------------------------------
  // A stretch that saw power_off is not a notification pulse, so it is not measured
  int   lo_cnt_q;
  int   lo_cnt_d;
  logic pw_q;
  logic pw_d;
  logic take;
  always_comb
  begin
    lo_cnt_d = upstream_hotplug_out ? 0 : lo_cnt_q + 1;
    pw_d     = (power_off || !upstream_hotplug_out) && (power_off || pw_q);
    take     = ce && aux_req.valid && !aux_busy;
  end
  always_ff @(posedge clk)
  begin
    lo_cnt_q <= rst_n ? lo_cnt_d : 0;
    pw_q     <= rst_n && pw_d;
  end

  // ------------------------------------------------
  // Assertions
  // ------------------------------------------------
  reset_vals_a: assert property ($rose(rst_n) |-> upstream_hotplug_out && !link_up
    && !aux_busy && trained_lanes == 5'h04) else $error("reset values wrong");
  pulse_len_a: assert property ($rose(upstream_hotplug_out) && !pw_q |-> lo_cnt_q == IRQ_PULSE_CYC)
    else $error("hot-plug pulse length wrong");
  pulse_bound_a: assert property (!pw_q |-> lo_cnt_q <= IRQ_PULSE_CYC)
    else $error("hot-plug line low too long");
  pwr_off_low_a: assert property (power_off |=> !upstream_hotplug_out)
    else $error("hot-plug line high while powered off");
  edid_busy_a: assert property (edid_rd |-> aux_busy ##1 (aux_rsp.valid && !aux_busy))
    else $error("EDID read handshake wrong");
  native_ans_a: assert property (take && aux_req.cmd[AUX_NATIVE_BIT] |=> aux_rsp.valid
    && aux_rsp.reply == AUX_ACK) else $error("native request not acknowledged");
  pwr_down_a: assert property (take && aux_req.cmd == AUX_CMD_NATIVE_WR && aux_req.addr == DPCD_PWR_STATE
    && aux_req.wdata == PWR_DOWN |=> !link_up) else $error("link kept after power down");
  lane_cnt_a: assert property (trained_lanes inside {5'h01, 5'h02, 5'h04})
    else $error("trained lane count illegal");
  std_map_a: assert property (cfg_in == $past(cfg_in) && !cfg_in.typec |=> main_lane == $past(phy_lane))
    else $error("standard lane map wrong");
  usb_zero_a: assert property (cfg_in == $past(cfg_in) && !cfg_in.usb_assignment
    |=> usb_rx_lane == '0 && usb_tx_lane == '0) else $error("usb lanes driven without usb map");

  cover property (edid_rd);
  cover property ($rose(link_up) && trained_lanes == 5'h02);
  cover property ($rose(upstream_hotplug_out) && !pw_q);
endmodule // ufplhc_ctrl_checker

bind ufplhc_ctrl ufplhc_ctrl_checker #(.LANE_W(LANE_W), .IRQ_PULSE_CYC(IRQ_PULSE_CYC)) ufplhc_ctrl_checker_inst (
  .clk(clk), .rst_n(rst_n), .ce(ce), .cfg_in(cfg_in), .phy_lane(phy_lane), .main_lane(main_lane),
  .usb_rx_lane(usb_rx_lane), .usb_tx_lane(usb_tx_lane), .aux_req(aux_req), .aux_rsp(aux_rsp),
  .aux_busy(aux_busy), .edid_rd(edid_rd), .power_off(power_off),
  .upstream_hotplug_out(upstream_hotplug_out), .link_up(link_up), .trained_lanes(trained_lanes));

// [verification/ufplhc_ctrl_test.sv]
// Self-checking bench for the upstream lane map and hot-plug controller
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin errors++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); end end
module ufplhc_ctrl_test;
  import ufplhc_pkg::*;
  localparam int LW  = 20;
  localparam int IRQ = 20;
  logic                 clk     = 1'b0;
  logic                 rst_n   = 1'b0;
  logic                 go      = 1'b0;
  logic [3:0]           cmd_s   = 4'h0;
  logic [19:0]          addr_s  = 20'h00000;
  logic [7:0]           wdata_s = 8'h00;
  ufplhc_cfg_t          cfg     = 3'h0;
  logic [3:0][LW-1:0]   phy     = '0;
  logic                 pos_pin = 1'b0;
  logic                 neg_pin = 1'b1;
  logic [3:0]           cr      = 4'h0;
  logic                 alt     = 1'b0;
  logic                 pwr     = 1'b0;
  logic                 dn_hp   = 1'b0;
  logic [3:0][LW-1:0]   ml;
  logic [LW-1:0]        usb_rx;
  logic [LW-1:0]        usb_tx;
  logic                 aux_p;
  logic                 aux_n;
  ufplhc_aux_req_t      req;
  ufplhc_aux_rsp_t      rsp;
  logic                 busy;
  logic [15:0]          edid_addr;
  logic                 edid_rd;
  logic [7:0]           edid_data;
  logic                 up_hp;
  logic                 link_up;
  logic [4:0]           tl;
  logic                 done;
  logic [1:0]           reply;
  logic [7:0]           rdata;
  int                   errors  = 0;
  int                   n_tests = 0;

  function automatic logic [7:0] edid_byte(input logic [15:0] a);
    return a[7:0] ^ {a[11:8], 4'h9};
  endfunction
  assign edid_data = edid_byte(edid_addr);
  always #4 clk = ~clk;

  ufplhc_ctrl #(.LANE_W(LW), .IRQ_PULSE_CYC(IRQ)) ufplhc_ctrl_inst (
    .clk(clk), .rst_n(rst_n), .ce(1'b1), .cfg_in(cfg), .phy_lane(phy), .aux_pos_sideband_pin(pos_pin),
    .aux_neg_sideband_pin(neg_pin), .main_lane(ml), .usb_rx_lane(usb_rx), .usb_tx_lane(usb_tx),
    .aux_p_out(aux_p), .aux_n_out(aux_n), .aux_req(req), .aux_rsp(rsp), .aux_busy(busy),
    .edid_addr(edid_addr), .edid_rd(edid_rd), .edid_data(edid_data), .lane_cr_done(cr),
    .altmode_policy(alt), .power_off(pwr), .downstream_hotplug_in(dn_hp),
    .upstream_hotplug_out(up_hp), .link_up(link_up), .trained_lanes(tl));
  ufplhc_src_model ufplhc_src_model_inst (
    .clk(clk), .rst_n(rst_n), .go(go), .cmd(cmd_s), .addr(addr_s), .wdata(wdata_s), .busy(busy),
    .rsp(rsp), .req(req), .done(done), .reply(reply), .rdata(rdata));

  // ------------------------------------------------
  // Shared tasks
  // ------------------------------------------------
  task automatic aux(input logic [3:0] c, input logic [19:0] a, input logic [7:0] w);
    int k;
    cmd_s   <= c;
    addr_s  <= a;
    wdata_s <= w;
    go      <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 20)
    begin
      @(posedge clk);
      k++;
    end
    `CHK("answer", 1'b1, done)
  endtask

  task automatic pulse(input string nm);
    int n;
    n = 0;
    while (up_hp !== 1'b0 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    n = 0;
    while (up_hp === 1'b0 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    `CHK(nm, IRQ, n)
  endtask

  task automatic train(input logic [3:0] cr_v, input logic a, input logic [3:0] tp, input logic [4:0] n);
    cr  <= cr_v;
    alt <= a;
    aux(AUX_CMD_NATIVE_WR, DPCD_TRAIN_PAT, {4'h0, TP_1});
    aux(AUX_CMD_NATIVE_WR, DPCD_TRAIN_PAT, {4'h0, tp});
    aux(AUX_CMD_NATIVE_WR, DPCD_TRAIN_PAT, {4'h0, TP_NONE});
    `CHK("link up", 1'b1, link_up)
    `CHK("lanes", n, tl)
  endtask

  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  task automatic test_map();
    logic [23:0]   tbl [5] = '{24'h773210, 24'h771032, 24'h107732, 24'h772301, 24'h237701};
    logic [2:0]    cc [5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
    logic [3:0]    f;
    logic [LW-1:0] e;
    logic [LW-1:0] got;
    for (int k = 0; k < 4; k++)
      phy[k] <= LW'(k + 1) * 20'h11111;
    pos_pin <= 1'b1;
    neg_pin <= 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      cfg <= cc[i];
      repeat (8) @(posedge clk);
      for (int j = 0; j < 6; j++)
      begin
        f = tbl[i][4*j +: 4];
        e = (f == 4'h7) ? '0 : LW'(f + 4'h1) * 20'h11111;
        got = (j < 4) ? ml[j] : ((j == 4) ? usb_rx : usb_tx);
        `CHK("lane", e, got)
      end
      `CHK("aux_p", !(cc[i][2] && cc[i][1]), aux_p)
      `CHK("aux_n", cc[i][2] && cc[i][1], aux_n)
    end
    cfg <= 3'h0;
    repeat (4) @(posedge clk);
    $display("test_map done");
  endtask

  task automatic test_hpd();
    aux(AUX_CMD_NATIVE_RD, DPCD_SINK_CNT, 8'h00);
    `CHK("sink none", SINK_NONE, rdata)
    `CHK("hotplug idle", 1'b1, up_hp)
    dn_hp <= 1'b1;
    pulse("plug pulse");
    aux(AUX_CMD_NATIVE_RD, DPCD_SINK_CNT, 8'h00);
    `CHK("sink one", SINK_ONE, rdata)
    dn_hp <= 1'b0;
    pulse("unplug pulse");
    pwr <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("powered off", 1'b0, up_hp)
    pwr <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("powered on", 1'b1, up_hp)
    $display("test_hpd done");
  endtask

  task automatic test_edid();
    aux(AUX_CMD_I2C_WR, 20'h00030, 8'h01);
    `CHK("segment ack", AUX_ACK, reply)
    aux(AUX_CMD_I2C_WR, 20'h00050, 8'hfe);
    `CHK("offset ack", AUX_ACK, reply)
    aux(AUX_CMD_I2C_RD | 4'h4, 20'h00050, 8'h00);
    `CHK("edid mot", edid_byte(16'h01fe), rdata)
    aux(AUX_CMD_I2C_RD, 20'h00050, 8'h00);
    `CHK("edid last", edid_byte(16'h01ff), rdata)
    aux(AUX_CMD_I2C_RD, 20'h00050, 8'h00);
    `CHK("edid wrap", edid_byte(16'h0000), rdata)
    aux(AUX_CMD_I2C_RD, 20'h0003a, 8'h00);
    `CHK("i2c nack", AUX_NACK, reply)
    aux(AUX_CMD_NATIVE_RD, 20'h00abc, 8'h00);
    `CHK("unmapped read", 8'h00, rdata)
    $display("test_edid done");
  endtask

  task automatic test_train();
    // pattern 4 used, no post-training adjust
    train(4'hf, 1'b0, TP_4, 5'h04);
    aux(AUX_CMD_NATIVE_RD, DPCD_LANE01_ST, 8'h00);
    `CHK("cr status", 8'h11, rdata & 8'h11)
    cfg <= 3'h6;
    repeat (4) @(posedge clk);
    `CHK("cfg held", phy[0], ml[0])
    aux(AUX_CMD_NATIVE_WR, DPCD_PWR_STATE, PWR_DOWN);
    cfg <= 3'h0;
    `CHK("power down", 1'b0, link_up)
    aux(AUX_CMD_NATIVE_WR, DPCD_TRAIN_PAT, 8'h00);
    `CHK("no short retrain", 1'b0, link_up)
    train(4'h3, 1'b1, TP_2, 5'h02);
    train(4'h1, 1'b1, TP_3, 5'h01);
    $display("test_train done");
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    test_map();
    test_hpd();
    test_edid();
    test_train();
    results();
  end

  // Whole run needs well under 2000 cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    results();
  end
endmodule // ufplhc_ctrl_test

// [verification/ufplhc_src_model.sv]
// Source-side aux master that issues one request and collects its answer
`timescale 1ns/100ps
module ufplhc_src_model (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        go,
  input  wire logic [3:0]                  cmd,
  input  wire logic [19:0]                 addr,
  input  wire logic [7:0]                  wdata,
  input  wire logic                        busy,
  input  wire ufplhc_pkg::ufplhc_aux_rsp_t rsp,
  output ufplhc_pkg::ufplhc_aux_req_t      req,
  output logic                             done,
  output logic [1:0]                       reply,
  output logic [7:0]                       rdata
);
  import ufplhc_pkg::*;
  always_ff @(posedge clk)
  begin
    done <= rsp.valid;
    if (!rst_n)
      req <= '0;
    else if (go)
      req <= '{1'b1, cmd, addr, wdata};
    // Idle fields flip so a stale request is never mistaken for a live one
    else if (req.valid && !busy)
      req <= '{1'b0, ~req.cmd, ~req.addr, ~req.wdata};
    if (rsp.valid)
    begin
      reply <= rsp.reply;
      rdata <= rsp.rdata;
    end
  end
endmodule // ufplhc_src_model
